// File: shared/gcs_pkg.sv
/*
 * Package for the glitchless clock switch: register map, reset values,
 * sequencing counts, state encoding and the register bus carrier.
 * Assumes a single 50 MHz system clock samples both input clocks.
 */
package gcs_pkg;

	// Register bus widths
	localparam int unsigned GCS_AW = 4;
	localparam int unsigned GCS_DW = 32;

	// Register offsets (byte addresses)
	localparam logic [GCS_AW-1:0] GCS_CTRL_OFS   = 4'h0;
	localparam logic [GCS_AW-1:0] GCS_STATUS_OFS = 4'h4;

	// Control field: low-hold cycles of the new clock, 1..3
	localparam int unsigned     GCS_HOLD_LSB   = 0;
	localparam int unsigned     GCS_HOLD_W     = 2;
	localparam logic [1:0]      GCS_HOLD_RST   = 2'h3;

	// Status fields
	localparam int unsigned GCS_ST_STATE_LSB = 0;
	localparam int unsigned GCS_ST_SEL_BIT   = 2;
	localparam int unsigned GCS_ST_FORCE_BIT = 3;

	// Old-clock cycles allowed before the output is forced low
	localparam logic [1:0] GCS_DRAIN_MAX = 2'h3;

	// Changeover states
	typedef enum logic [1:0] {
		GCS_RUN   = 2'b00,
		GCS_DRAIN = 2'b01,
		GCS_HOLD  = 2'b10
	} gcs_state_t;

	// Register bus request
	typedef struct packed {
		logic [GCS_AW-1:0] addr;
		logic [GCS_DW-1:0] wdata;
		logic              wr;
		logic              rd;
	} gcs_bus_req_t;

endpackage : gcs_pkg

// File: core/gcs_edge.sv
/*
 * Level sampler and edge finder for one incoming clock.
 * Assumes the input is already synchronous to clk.
 */
`timescale 1ns/10ps
module gcs_edge (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// Sampled clock
	input  wire logic lvl_in,
	// Results
	output logic      lvl_q,
	output logic      rise,
	output logic      fall
);
	logic prev_q; // Level one cycle earlier

	// Two-stage history for edge finding
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lvl_q  <= 1'b0;
			prev_q <= 1'b0;
		end else begin
			lvl_q  <= lvl_in;
			prev_q <= lvl_q;
		end
	end

	assign rise = lvl_q & ~prev_q;
	assign fall = ~lvl_q & prev_q;

endmodule : gcs_edge

// File: core/gcs_switch.sv
/*
 * Glitchless two-input clock switch with force select, output gate
 * with idle level, power down, and a small control/status port.
 * Assumes both input clocks and all pins are synchronous to clk and
 * well below half its rate; outputs lag the inputs by a few cycles.
 * Assumes the controller keeps force high while an input is dead,
 * and gates the outputs itself around power down and gate changes.
 * Force acts one clk cycle late: the block has no path that does not
 * pass through a flop, so the low is synchronous, not truly instant.
 */
// Local design decisions: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
module gcs_switch (
	// Clock and reset
	input  wire logic                   clk,
	input  wire logic                   rst_n,
	// Input clocks
	input  wire logic                   primary_clk_in,
	input  wire logic                   secondary_clk_in,
	// Control pins
	input  wire logic                   input_choice,
	input  wire logic                   force_choice,
	input  wire logic                   output_gate_en,
	input  wire logic                   gate_idle_level,
	input  wire logic                   power_down_n,
	// Register port
	input  wire gcs_pkg::gcs_bus_req_t  bus_req,
	output logic [gcs_pkg::GCS_DW-1:0]  rd_data,
	// Clock outputs, true and complement
	output logic [1:0]                  clk_out,
	output logic [1:0]                  clk_out_c
);
	import gcs_pkg::*;

	// Sampled clocks and edges
	logic       pri_lvl, pri_rise, pri_fall;
	logic       sec_lvl, sec_rise, sec_fall;
	// Sequencer state
	gcs_state_t st_q, st_d;
	logic       cur_sel_q, cur_sel_d;   // Input now feeding the switch
	logic       sw_q, sw_d;             // Switched clock before gating
	logic [1:0] cnt_q, cnt_d;           // Drain or hold cycle count
	logic       force_q;                // Force level last cycle
	logic [1:0] hold_q;                 // Hold cycles from software

	// Edge finders, one per input clock
	// Both run all the time, so the choice can move without delay;
	// a dead clock simply never shows an edge here.
	gcs_edge u_pri (
		.clk    (clk),
		.rst_n  (rst_n),
		.lvl_in (primary_clk_in),
		.lvl_q  (pri_lvl),
		.rise   (pri_rise),
		.fall   (pri_fall)
	);
	gcs_edge u_sec (
		.clk    (clk),
		.rst_n  (rst_n),
		.lvl_in (secondary_clk_in),
		.lvl_q  (sec_lvl),
		.rise   (sec_rise),
		.fall   (sec_fall)
	);

	// Selection decode
	// Only the input now feeding the switch is watched, so the other
	// input may stop or run at any rate without touching the output.
	wire cur_lvl    = cur_sel_q ? sec_lvl  : pri_lvl;
	wire cur_rise   = cur_sel_q ? sec_rise : pri_rise;
	wire cur_fall   = cur_sel_q ? sec_fall : pri_fall;
	wire force_rise = force_choice & ~force_q;
	// Changeover only without force, so a dead clock is never watched
	wire change_req = ~force_choice & (input_choice != cur_sel_q);
	// Zero hold setting treated as one
	wire [1:0] hold_lim  = (hold_q == 2'h0) ? 2'h1 : hold_q;
	wire       hold_done = cur_rise & (cnt_q == hold_lim - 2'h1);
	wire       drain_to  = cur_rise & (cnt_q == GCS_DRAIN_MAX - 2'h1);

	// Sequencer next state
	// RUN passes the chosen level through. A new choice moves to DRAIN,
	// which lets the old clock finish its high phase and then parks the
	// output low. HOLD keeps it low for the set number of rising edges
	// of the new clock and lets it go high on the last one, so the first
	// new pulse is always a full one. A force rise skips DRAIN entirely
	// and may clip a high phase; that is the price of leaving a dead clock.
	always_comb begin
		st_d      = st_q;
		cur_sel_d = cur_sel_q;
		sw_d      = sw_q;
		cnt_d     = cnt_q;
		if (force_rise) begin
			// Low at once, restart from current choice; may clip a pulse
			sw_d      = 1'b0;
			cur_sel_d = input_choice;
			cnt_d     = 2'h0;
			st_d      = GCS_HOLD;
		end else begin
			case (st_q)
				GCS_RUN: begin
					sw_d = cur_lvl;
					if (change_req) begin
						cnt_d = 2'h0;
						st_d  = GCS_DRAIN;
					end
				end
				GCS_DRAIN: begin
					sw_d = cur_lvl;
					// Falling edge or low level ends it; an old clock stuck high never times out
					if (cur_fall || drain_to || !cur_lvl) begin
						sw_d      = 1'b0;
						cur_sel_d = input_choice;
						cnt_d     = 2'h0;
						st_d      = GCS_HOLD;
					end else if (cur_rise) begin
						cnt_d = cnt_q + 2'h1;
					end
				end
				GCS_HOLD: begin
					sw_d = 1'b0;
					if (hold_done) begin
						sw_d = 1'b1;
						st_d = GCS_RUN;
					end else if (cur_rise) begin
						cnt_d = cnt_q + 2'h1;
					end
				end
				default: begin
					sw_d = 1'b0;
					st_d = GCS_RUN;
				end
			endcase
		end
	end

	// Sequencer registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q      <= GCS_RUN;
			cur_sel_q <= 1'b0;
			sw_q      <= 1'b0;
			cnt_q     <= 2'h0;
			force_q   <= 1'b0;
		end else begin
			st_q      <= st_d;
			cur_sel_q <= cur_sel_d;
			sw_q      <= sw_d;
			cnt_q     <= cnt_d;
			force_q   <= force_choice;
		end
	end

	// Output stage: power down beats gate, gate beats clock
	// The gate is applied here without regard to the clock phase, so a
	// badly timed gate change can still give a short pulse; the
	// controller has to place its gate changes on a low phase.
	wire [1:0] out_t = !power_down_n   ? 2'b11 :
	                   !output_gate_en ? {2{gate_idle_level}} :
	                   {2{sw_d}};
	wire [1:0] out_c = !power_down_n   ? 2'b11 : ~out_t;

	// Output flops
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			clk_out   <= 2'b00;
			clk_out_c <= 2'b11;
		end else begin
			clk_out   <= out_t;
			clk_out_c <= out_c;
		end
	end

	// Register decode
	// Unmapped addresses select nothing, so their reads give zero and
	// their writes are dropped.
	wire ctrl_sel = bus_req.addr == GCS_CTRL_OFS;
	wire stat_sel = bus_req.addr == GCS_STATUS_OFS;
	logic [GCS_DW-1:0] rd_mux;
	always_comb begin
		rd_mux = '0;
		if (ctrl_sel) begin
			rd_mux[GCS_HOLD_LSB +: GCS_HOLD_W] = hold_q;
		end else if (stat_sel) begin
			rd_mux[GCS_ST_STATE_LSB +: 2] = st_q;
			rd_mux[GCS_ST_SEL_BIT]        = cur_sel_q;
			rd_mux[GCS_ST_FORCE_BIT]      = force_q;
		end
	end

	// Control write and read data; unmapped reads give zero
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hold_q  <= GCS_HOLD_RST;
			rd_data <= '0;
		end else begin
			if (bus_req.wr && ctrl_sel)
				hold_q <= bus_req.wdata[GCS_HOLD_LSB +: GCS_HOLD_W];
			rd_data <= bus_req.rd ? rd_mux : '0;
		end
	end

	// Checks
	// All checks run on clk and are off during reset; they watch the
	// sequencer registers and the output flops, never the pins alone.
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence drain_ends_s;
		(st_q == GCS_DRAIN) && !force_rise && (cur_fall || drain_to);
	endsequence
	sequence hold_ends_s;
		(st_q == GCS_HOLD) && !force_rise && hold_done;
	endsequence
	sequence force_s;
		force_rise;
	endsequence

	drain_low_a: assert property (drain_ends_s |=> !sw_q && st_q == GCS_HOLD)
		else $error("drain did not drop output low");
	drain_bound_a: assert property ((st_q == GCS_DRAIN) |-> cnt_q < GCS_DRAIN_MAX)
		else $error("drain lasted too many cycles");
	hold_bound_a: assert property ((st_q == GCS_HOLD) |-> cnt_q < 2'h3 && !sw_q)
		else $error("hold too long or not low");
	resume_rise_a: assert property (hold_ends_s |=> sw_q && st_q == GCS_RUN)
		else $error("resume not on rising edge");
	force_low_a: assert property (force_rise |=> !sw_q ##0 st_q == GCS_HOLD)
		else $error("force did not drive low");
	force_sel_a: assert property (force_rise |=> cur_sel_q == $past(input_choice))
		else $error("force restarted from wrong input");
	force_steady_a: assert property (force_choice && st_q == GCS_RUN |=> st_q != GCS_DRAIN)
		else $error("changeover started under force");
	run_follow_a: assert property ((st_q == GCS_RUN) && !force_rise |=>
		sw_q == ($past(cur_sel_q) ? $past(sec_lvl) : $past(pri_lvl)))
		else $error("output not following chosen input");
	pwr_down_a: assert property (!power_down_n |=> clk_out == 2'b11 && clk_out_c == 2'b11)
		else $error("power down outputs not high");
	gate_idle_a: assert property (power_down_n && !output_gate_en |=>
		clk_out == {2{$past(gate_idle_level)}} && clk_out_c == ~clk_out)
		else $error("gated outputs not at idle level");

	// A new choice without force always enters the drain
	drain_start_a: assert property ((st_q == GCS_RUN) && change_req && !force_rise
		|=> st_q == GCS_DRAIN)
		else $error("changeover did not start draining");

	// Drain keeps the old input until its high phase ends
	drain_keep_a: assert property ((st_q == GCS_DRAIN) && !force_rise && cur_lvl
		&& !cur_fall && !drain_to |=> st_q == GCS_DRAIN && cur_sel_q == $past(cur_sel_q))
		else $error("drain left the old input early");

	// An old input already low ends the drain at once
	drain_dead_a: assert property ((st_q == GCS_DRAIN) && !force_rise && !cur_lvl
		|=> st_q == GCS_HOLD && cur_sel_q == $past(input_choice))
		else $error("stuck old input not abandoned");

	// Selection stays put while running
	run_sel_a: assert property ((st_q == GCS_RUN) && !force_rise
		|=> cur_sel_q == $past(cur_sel_q))
		else $error("selection moved while running");

	// Selection stays put while holding low
	hold_sel_a: assert property ((st_q == GCS_HOLD) && !force_rise
		|=> cur_sel_q == $past(cur_sel_q))
		else $error("selection moved while holding");

	// Hold only counts rising edges of the new input
	hold_wait_a: assert property ((st_q == GCS_HOLD) && !force_rise && !cur_rise
		|=> st_q == GCS_HOLD && cnt_q == $past(cnt_q))
		else $error("hold advanced without a new edge");

	// A force restarts the hold count from zero
	force_cnt_a: assert property (force_s |=> cnt_q == 2'h0)
		else $error("force did not restart hold count");

	// Ungated outputs carry the switched clock outside power down
	out_follow_a: assert property (power_down_n && output_gate_en |=> clk_out == {2{sw_q}})
		else $error("outputs not carrying switched clock");

	// Complement mirrors true output outside power down
	pair_mirror_a: assert property (power_down_n |=> clk_out_c == ~clk_out)
		else $error("complement not inverse of true output");

	// Both true outputs always agree
	out_pair_a: assert property (clk_out[0] == clk_out[1])
		else $error("true outputs differ");

endmodule : gcs_switch

// File: verif/gcs_clk_src.sv
/*
 * Far-side model: two slow input clocks for the switch.
 * Assumes clk is the 50 MHz system clock; a killed clock sits low.
 */
`timescale 1ns/10ps
module gcs_clk_src #(
	parameter int P_HALF = 4,	// Primary half period in clk cycles
	parameter int S_HALF = 6	// Secondary half period in clk cycles
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// Dead-clock controls
	input  wire logic kill_p,
	input  wire logic kill_s,
	// Input clocks
	output logic      primary_clk_in,
	output logic      secondary_clk_in
);
	int p_cnt;	// Primary phase count
	int s_cnt;	// Secondary phase count

	// Free-running dividers; a dead clock stays at DC low
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			p_cnt <= 0;
			s_cnt <= 0;
			primary_clk_in <= 1'b0;
			secondary_clk_in <= 1'b0;
		end else begin
			p_cnt <= (p_cnt == P_HALF - 1) ? 0 : p_cnt + 1;
			s_cnt <= (s_cnt == S_HALF - 1) ? 0 : s_cnt + 1;
			if (kill_p) primary_clk_in <= 1'b0;
			else if (p_cnt == P_HALF - 1) primary_clk_in <= ~primary_clk_in;
			if (kill_s) secondary_clk_in <= 1'b0;
			else if (s_cnt == S_HALF - 1) secondary_clk_in <= ~secondary_clk_in;
		end
	end
endmodule : gcs_clk_src

// File: verif/tb.sv
/*
 * Self-checking bench for the clock switch: changeover, force, gate,
 * power down and register port.
 * Assumes gcs_clk_src makes input clocks of 8 and 12 clk periods.
 */
`timescale 1ns/10ps
module tb;
	import gcs_pkg::*;
	logic clk = 1'b0;	// System clock
	logic rst_n = 1'b0;	// Reset, active low
	logic ic = 1'b0, fc = 1'b0, ge = 1'b1, gl = 1'b0, pd = 1'b1;	// Control pins
	logic kp = 1'b0, ks = 1'b0;	// Dead-clock controls
	logic pclk, sclk;	// Input clocks
	gcs_bus_req_t rq = '0;	// Register request
	logic [31:0] rd_data;	// Read data
	logic [1:0] co, coc;	// Clock outputs
	int err_total = 0, total_checks = 0;
	int n;

	always #10 clk = ~clk;

	gcs_clk_src gcs_clk_src_inst (.clk(clk), .rst_n(rst_n), .kill_p(kp), .kill_s(ks),
		.primary_clk_in(pclk), .secondary_clk_in(sclk));
	gcs_switch gcs_switch_inst (.clk(clk), .rst_n(rst_n), .primary_clk_in(pclk),
		.secondary_clk_in(sclk), .input_choice(ic), .force_choice(fc),
		.output_gate_en(ge), .gate_idle_level(gl), .power_down_n(pd),
		.bus_req(rq), .rd_data(rd_data), .clk_out(co), .clk_out_c(coc));

	// Counts and verdict
	task automatic wrap_up;
		$display("Checks %0d, mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : wrap_up

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			err_total++;
			$display("Error %s exp %h seen %h", nm, e, g);
		end
	endtask : chk

	// Bounded wait on the true output, sampled mid-cycle
	task automatic wait_lvl(input logic v, input int lim);
		total_checks++;
		while (co[0] !== v && n < lim) begin
			@(negedge clk);
			n++;
		end
		if (co[0] !== v) begin
			err_total++;
			$display("Error clk_out level exp %b seen %b", v, co[0]);
			wrap_up();
		end
	endtask : wait_lvl

	// Cycles from one output rise to the next
	task automatic period(input int e);
		n = 0;
		wait_lvl(1'b0, 40);
		wait_lvl(1'b1, 40);
		n = 0;
		wait_lvl(1'b0, 40);
		wait_lvl(1'b1, 40);
		chk("period", e, n);
	endtask : period

	// Read one register, data stands the cycle after the strobe
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		@(posedge clk);
		rq.addr <= a;
		rq.rd <= 1'b1;
		@(posedge clk);
		rq.rd <= 1'b0;
		@(negedge clk);
		chk("rd_data", e, rd_data);
	endtask : rd

	// Write one register: one cycle with the write strobe high
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		rq.addr <= a;
		rq.wdata <= d;
		rq.wr <= 1'b1;
		@(posedge clk);
		rq.wr <= 1'b0;
	endtask : wr

	// Hold setting round trip; unmapped writes dropped, upper bits zero
	task automatic t_reg;
		wr(GCS_CTRL_OFS, 32'hffff_fff1);
		rd(GCS_CTRL_OFS, 32'h1);
		wr(4'h8, 32'h2);
		rd(GCS_CTRL_OFS, 32'h1);
		wr(GCS_CTRL_OFS, 32'h3);
		rd(GCS_CTRL_OFS, 32'h3);
	endtask : t_reg

	task automatic t_reset;
		chk("clk_out", 2'h0, co);
		chk("clk_out_c", 2'h3, coc);
		rd(GCS_CTRL_OFS, 32'h3);
		rd(4'h8, 32'h0);
	endtask : t_reset

	task automatic t_switch;
		period(8);
		@(posedge clk) ic <= 1'b1;
		n = 0;
		wait_lvl(1'b0, 27);
		n = 0;
		wait_lvl(1'b1, 39);
		period(12);
		rd(GCS_STATUS_OFS, 32'h4);
	endtask : t_switch

	task automatic t_force;
		@(posedge clk) ic <= 1'b0;
		@(posedge clk) fc <= 1'b1;
		n = 0;
		wait_lvl(1'b1, 40);
		@(posedge clk) fc <= 1'b0;
		@(posedge clk) fc <= 1'b1;
		n = 0;
		wait_lvl(1'b0, 3);
		period(8);
		@(posedge clk) ks <= 1'b1;
		period(8);
		@(posedge clk) begin
			ks <= 1'b0;
			kp <= 1'b1;
			fc <= 1'b0;
		end
		@(posedge clk) ic <= 1'b1;
		@(posedge clk) fc <= 1'b1;
		period(12);
		@(posedge clk) kp <= 1'b0;
	endtask : t_force

	task automatic t_gate;
		for (int v = 0; v < 2; v++) begin
			n = 0;
			wait_lvl(1'b0, 40);
			@(posedge clk) begin
				ge <= 1'b0;
				gl <= v[0];
			end
			repeat (4) @(negedge clk);
			chk("gated clk_out", {2{v[0]}}, co);
			chk("gated clk_out_c", {2{~v[0]}}, coc);
			@(posedge clk) pd <= 1'b0;
			repeat (4) @(negedge clk);
			chk("pd clk_out", 2'h3, co);
			chk("pd clk_out_c", 2'h3, coc);
			@(posedge clk) pd <= 1'b1;
			repeat (4) @(posedge clk);
			ge <= 1'b1;
		end
		period(12);
	endtask : t_gate

	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_reg();
		t_switch();
		t_force();
		t_gate();
		wrap_up();
	end
endmodule : tb
